// ---- core/wdc_top.sv ----
`timescale 1ns/10ps
module wdc_top
#(
    parameter int CHECK_WINDOW = wdc_pkg::CHECK_WINDOW_CYCLES,
    parameter int OSC_EDGES = wdc_pkg::OSC_OK_EDGES
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic osc_clk_pin,
    input wire logic monitor_fail_pin,
    input wire logic pseudo_stop,
    input wire logic wait_instruction,
    input wire logic wake_irq,
    input wire logic wdctl_wr,
    input wire logic [wdc_pkg::WD_RATE_W-1:0] wd_rate_in,
    input wire logic windowed_service_enable,
    input wire logic watchdog_pseudo_stop_enable,
    input wire logic svc_wr,
    input wire logic [15:0] svc_data,
    input wire logic prc_wr,
    input wire logic [wdc_pkg::PRD_RATE_W-1:0] periodic_rate_control,
    input wire logic periodic_irq_enable,
    input wire logic periodic_pseudo_stop_enable,
    input wire logic periodic_flag_clr,
    input wire logic clock_monitor_enable,
    input wire logic self_clock_enable,
    input wire logic self_clock_irq_enable,
    input wire logic self_clock_flag_clr,
    input wire logic pll_select_wr,
    input wire logic pll_select_in,
    input wire wdc_pkg::wdc_wait_cfg_type wait_cfg,
    output logic watchdog_reset,
    output logic monitor_fail_reset,
    output logic periodic_irq_flag,
    output logic periodic_irq,
    output logic self_clock_irq_flag,
    output logic self_clock_irq,
    output logic self_clock_mode,
    output logic pll_clock_select,
    output logic pll_enable,
    output logic regulator_enable,
    output logic core_clk_en,
    output logic sys_clk_en,
    output logic osc_reduced,
    output logic wait_active
);
    import wdc_pkg::*;

    logic osc_meta, osc_sync, osc_prev, osc_tick;
    logic cm_meta, cm_sync, cm_prev, cm_rise;
    logic [WD_RATE_W-1:0] wd_rate_reg;
    logic wd_win_reg, wd_pse_reg, wd_armed_reg;
    logic [PRD_RATE_W-1:0] prd_rate_reg;
    logic wd_on, wd_run, wd_restart, wd_expire, wd_late;
    logic prd_on, prd_run, prd_restart, prd_expire;
    logic svc_bad, svc_early, svc_pair;
    logic [SHIFT_W-1:0] wd_shift, prd_shift;
    logic [TMR_W-1:0] wd_count, prd_count;
    logic scm_enter, qc_start, qc_busy, qc_ok, por_pending, keep_pll, wake;
    wdc_wait_state_type wait_state_reg;

    // oscillator and monitor pins cross into ref_clk by two flops each
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
            cm_meta <= 1'b0;
            cm_sync <= 1'b0;
            cm_prev <= 1'b0;
        end
        else
        begin
            osc_meta <= osc_clk_pin;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
            cm_meta <= monitor_fail_pin;
            cm_sync <= cm_meta;
            cm_prev <= cm_sync;
        end
    end

    assign osc_tick = osc_sync && !osc_prev;
    assign cm_rise = cm_sync && !cm_prev;

    // watchdog configuration; reset leaves rate zero, i.e. off
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wd_rate_reg <= WD_RATE_OFF;
            wd_win_reg <= 1'b0;
            wd_pse_reg <= 1'b0;
        end
        else if (wdctl_wr)
        begin
            wd_rate_reg <= wd_rate_in;
            wd_win_reg <= windowed_service_enable;
            wd_pse_reg <= watchdog_pseudo_stop_enable;
        end
    end

    // periodic rate; a write also restarts the running period
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            prd_rate_reg <= PRD_RATE_OFF;
        else if (prc_wr)
            prd_rate_reg <= periodic_rate_control;
    end

    // timer gating: zero rate stops, wait bits and pseudo-stop freeze
    assign wd_on = wd_rate_reg != WD_RATE_OFF;
    assign wd_run = wd_on && !(wait_active && wait_cfg.watchdog_stop)
        && !(pseudo_stop && !wd_pse_reg);
    assign prd_on = prd_rate_reg != PRD_RATE_OFF;
    assign prd_run = prd_on && !(wait_active && wait_cfg.periodic_stop)
        && !(pseudo_stop && !periodic_pseudo_stop_enable);
    assign wd_shift = WD_SHIFT_BASE + SHIFT_W'({wd_rate_reg, 1'b0});
    assign prd_shift = PRD_SHIFT_BASE + SHIFT_W'(prd_rate_reg);

    // service decode: window test applies to either service value
    assign svc_bad = svc_wr && (svc_data != SVC_ARM) && (svc_data != SVC_FIRE);
    assign svc_early = svc_wr && wd_win_reg && !wd_late;
    assign svc_pair = svc_wr && (svc_data == SVC_FIRE) && wd_armed_reg && !svc_early;
    assign wd_restart = !wd_on || wdctl_wr || svc_pair;
    assign prd_restart = !prd_on || prc_wr;

    wdc_timer #(
        .CNT_W(TMR_W)
    ) u_wd_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .tick(osc_tick),
        .run(wd_run),
        .restart(wd_restart),
        .shift(wd_shift),
        .expire(wd_expire),
        .late(wd_late),
        .count(wd_count)
    );

    wdc_timer #(
        .CNT_W(TMR_W)
    ) u_prd_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .tick(osc_tick),
        .run(prd_run),
        .restart(prd_restart),
        .shift(prd_shift),
        .expire(prd_expire),
        .late(),
        .count(prd_count)
    );

    // first half of the service pair; any other write disarms
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            wd_armed_reg <= 1'b0;
        else if (svc_wr)
            wd_armed_reg <= (svc_data == SVC_ARM);
    end

    // one-cycle reset request to the reset generator
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            watchdog_reset <= 1'b0;
        else
            watchdog_reset <= wd_on && (wd_expire || svc_bad || svc_early);
    end

    // periodic flag: a time-out in the clear cycle still sets it
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            periodic_irq_flag <= 1'b0;
            periodic_irq <= 1'b0;
        end
        else
        begin
            if (prd_expire)
                periodic_irq_flag <= 1'b1;
            else if (periodic_flag_clr)
                periodic_irq_flag <= 1'b0;
            periodic_irq <= periodic_irq_flag && periodic_irq_enable;
        end
    end

    // monitor failure: fallback needs both monitor and self-clock on
    assign scm_enter = cm_rise && clock_monitor_enable && self_clock_enable;
    assign qc_start = por_pending || (cm_rise && clock_monitor_enable);

    // power-on also asks for a quality check, one cycle after release
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            por_pending <= 1'b1;
        else
            por_pending <= 1'b0;
    end

    wdc_qcheck #(
        .WINDOW(CHECK_WINDOW),
        .EDGES(OSC_EDGES)
    ) u_qcheck (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(qc_start),
        .osc_tick(osc_tick),
        .busy(qc_busy),
        .osc_ok(qc_ok)
    );

    // self-clock mode and its flag; a good check hands back to the osc
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            self_clock_mode <= 1'b0;
            self_clock_irq_flag <= 1'b0;
            self_clock_irq <= 1'b0;
            monitor_fail_reset <= 1'b0;
        end
        else
        begin
            if (scm_enter)
                self_clock_mode <= 1'b1;
            else if (qc_ok)
                self_clock_mode <= 1'b0;
            if (scm_enter)
                self_clock_irq_flag <= 1'b1;
            else if (self_clock_flag_clr)
                self_clock_irq_flag <= 1'b0;
            self_clock_irq <= self_clock_irq_flag && self_clock_irq_enable;
            monitor_fail_reset <= cm_rise && clock_monitor_enable && !self_clock_enable;
        end
    end

    // PLL and regulator must stay up while self-clocked or checking
    assign keep_pll = self_clock_mode || qc_busy;
    assign wake = wake_irq || periodic_irq || self_clock_irq;

    // wait entry walks one step a cycle; only a wake leaves idle
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            wait_state_reg <= W_RUN;
        else
        begin
            unique case (wait_state_reg)
                W_RUN:
                    if (wait_instruction)
                        wait_state_reg <= W_SEL;
                W_SEL: wait_state_reg <= W_PLL;
                W_PLL: wait_state_reg <= W_CORE;
                W_CORE: wait_state_reg <= W_SYS;
                W_SYS: wait_state_reg <= W_IDLE;
                W_IDLE:
                    if (wake)
                        wait_state_reg <= W_RUN;
            endcase
        end
    end

    // hardware clears of the select win over a software write
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            pll_clock_select <= 1'b0;
        else if (scm_enter)
            pll_clock_select <= 1'b0;
        else if (wait_state_reg == W_SEL && wait_cfg.pll_stop)
            pll_clock_select <= 1'b0;
        else if (pll_select_wr)
            pll_clock_select <= pll_select_in;
    end

    // clock gates; the select stays cleared after a PLL stop in wait
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pll_enable <= 1'b1;
            core_clk_en <= 1'b1;
            sys_clk_en <= 1'b1;
        end
        else if (wait_state_reg == W_IDLE && wake)
        begin
            pll_enable <= 1'b1;
            core_clk_en <= 1'b1;
            sys_clk_en <= 1'b1;
        end
        else
        begin
            if (keep_pll)
                pll_enable <= 1'b1;
            else if (wait_state_reg == W_PLL && wait_cfg.pll_stop)
                pll_enable <= 1'b0;
            if (wait_state_reg == W_CORE && (wait_cfg.core_stop || wait_cfg.system_stop))
                core_clk_en <= 1'b0;
            if (wait_state_reg == W_SYS && wait_cfg.system_stop)
                sys_clk_en <= 1'b0;
        end
    end

    // wait status, oscillator amplitude and regulator request
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wait_active <= 1'b0;
            osc_reduced <= 1'b0;
            regulator_enable <= 1'b1;
        end
        else
        begin
            wait_active <= (wait_state_reg == W_SYS) || (wait_state_reg == W_IDLE && !wake);
            osc_reduced <= wait_active && wait_cfg.reduced_osc;
            regulator_enable <= !pseudo_stop || keep_pll;
        end
    end

    chk_wd_off_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!wd_on && !wdctl_wr) |=> !watchdog_reset)
        else $error("watchdog reset while watchdog off");
    chk_wd_expiry_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wd_on && wd_expire) |=> watchdog_reset ##1 !watchdog_reset)
        else $error("expiry did not give a one-cycle reset");
    chk_bad_service: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wd_on && svc_wr && svc_data != SVC_ARM && svc_data != SVC_FIRE) |=> watchdog_reset)
        else $error("bad service value did not reset");
    chk_early_service: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wd_on && svc_wr && wd_win_reg && wd_count < (TMR_W'(1) << wd_shift) - ((TMR_W'(1) << wd_shift) >> 2))
        |=> watchdog_reset)
        else $error("early windowed service did not reset");
    chk_pair_restart: assert property (@(posedge ref_clk) disable iff (!rstn)
        (svc_wr && svc_data == SVC_FIRE && wd_armed_reg && !svc_early && wd_on && !wd_expire)
        |=> wd_count == '0 && !watchdog_reset)
        else $error("service pair did not restart watchdog");
    chk_prd_flag_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        prd_expire |=> periodic_irq_flag && prd_count == '0)
        else $error("periodic time-out did not set flag");
    chk_prd_restart: assert property (@(posedge ref_clk) disable iff (!rstn)
        prc_wr |=> prd_count == '0)
        else $error("rate write did not restart period");
    chk_cm_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
        (cm_rise && clock_monitor_enable && !self_clock_enable) |=> monitor_fail_reset && !self_clock_mode)
        else $error("monitor failure did not reset");
    chk_scm_entry: assert property (@(posedge ref_clk) disable iff (!rstn)
        scm_enter |=> self_clock_mode && self_clock_irq_flag && !pll_clock_select && qc_busy)
        else $error("self-clock entry incomplete");
    chk_wait_order: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wait_state_reg == W_SEL && wait_cfg.pll_stop && wait_cfg.system_stop && !keep_pll && !scm_enter)
        |=> !pll_clock_select ##1 !pll_enable ##1 !core_clk_en ##1 !sys_clk_en)
        else $error("wait entry order broken");
    chk_osc_ok_exit: assert property (@(posedge ref_clk) disable iff (!rstn)
        (qc_ok && !scm_enter) |=> !self_clock_mode)
        else $error("good oscillator did not leave self-clock");

    cov_wd_pair: cover property (@(posedge ref_clk) disable iff (!rstn) svc_pair && wd_on);
    cov_prd_irq: cover property (@(posedge ref_clk) disable iff (!rstn) periodic_irq);
    cov_wait_wake: cover property (@(posedge ref_clk) disable iff (!rstn)
        wait_state_reg == W_IDLE && wake);
    cov_scm_exit: cover property (@(posedge ref_clk) disable iff (!rstn) self_clock_mode && qc_ok);
endmodule // wdc_top

// ---- core/wdc_pkg.sv ----
package wdc_pkg;
    // service pair that restarts the watchdog
    localparam logic [15:0] SVC_ARM = 16'h0055;
    localparam logic [15:0] SVC_FIRE = 16'h00aa;
    // field widths
    localparam int WD_RATE_W = 3;
    localparam int PRD_RATE_W = 4;
    localparam int SHIFT_W = 5;
    localparam int TMR_W = 26;
    // period is 2**shift oscillator ticks; shift = base + step * code
    localparam logic [SHIFT_W-1:0] WD_SHIFT_BASE = 5'h08;
    localparam logic [SHIFT_W-1:0] PRD_SHIFT_BASE = 5'h09;
    localparam logic [WD_RATE_W-1:0] WD_RATE_OFF = 3'h0;
    localparam logic [PRD_RATE_W-1:0] PRD_RATE_OFF = 4'h0;
    // clock quality check: window length and edges that mean osc ok
    localparam int CHECK_WINDOW_CYCLES = 50000;
    localparam int OSC_OK_EDGES = 4096;

    // wait-mode gating bits; system_stop also stops the core clock
    typedef struct packed {
        logic pll_stop;
        logic core_stop;
        logic system_stop;
        logic periodic_stop;
        logic watchdog_stop;
        logic reduced_osc;
    } wdc_wait_cfg_type;

    // wait entry sequence
    typedef enum logic [2:0] {
        W_RUN,
        W_SEL,
        W_PLL,
        W_CORE,
        W_SYS,
        W_IDLE
    } wdc_wait_state_type;
endpackage

// ---- core/wdc_timer.sv ----
`timescale 1ns/10ps
module wdc_timer
#(
    parameter int CNT_W = wdc_pkg::TMR_W
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic tick,
    input wire logic run,
    input wire logic restart,
    input wire logic [wdc_pkg::SHIFT_W-1:0] shift,
    output logic expire,
    output logic late,
    output logic [CNT_W-1:0] count
);
    import wdc_pkg::*;
    logic [CNT_W-1:0] period;

    // power-of-two period, last quarter marks the service window
    assign period = CNT_W'(1) << shift;
    assign expire = run && tick && (count == period - CNT_W'(1));
    assign late = count >= (period - (period >> 2));

    // count freezes while not running, so gating never loses progress
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            count <= '0;
        else if (restart || expire)
            count <= '0;
        else if (run && tick)
            count <= count + CNT_W'(1);
    end
endmodule // wdc_timer

// ---- core/wdc_qcheck.sv ----
`timescale 1ns/10ps
module wdc_qcheck
#(
    parameter int WINDOW = wdc_pkg::CHECK_WINDOW_CYCLES,
    parameter int EDGES = wdc_pkg::OSC_OK_EDGES
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic osc_tick,
    output logic busy,
    output logic osc_ok
);
    import wdc_pkg::*;
    localparam int WIN_W = $clog2(WINDOW + 1);
    localparam int EDG_W = $clog2(EDGES + 1);
    logic [WIN_W-1:0] win_cnt;
    logic [EDG_W-1:0] edge_cnt;
    logic win_end;

    assign osc_ok = busy && osc_tick && (edge_cnt == EDG_W'(EDGES - 1));
    assign win_end = win_cnt == WIN_W'(WINDOW - 1);

    // a failed window simply starts the next one until the osc is good
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy <= 1'b0;
            win_cnt <= '0;
            edge_cnt <= '0;
        end
        else if (start || (busy && win_end))
        begin
            busy <= 1'b1;
            win_cnt <= '0;
            edge_cnt <= '0;
        end
        else if (osc_ok)
            busy <= 1'b0;
        else if (busy)
        begin
            win_cnt <= win_cnt + WIN_W'(1);
            if (osc_tick)
                edge_cnt <= edge_cnt + EDG_W'(1);
        end
    end
endmodule // wdc_qcheck

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
    import wdc_pkg::*;
    typedef struct packed
    {
        wdc_wait_cfg_type cfg;
        logic [4:0] exp;
    } wdc_tb_row_type;
    logic ref_clk = 1'b0;
    logic rstn;
    logic osc_clk_pin = 1'b0;
    logic osc_run = 1'b1;
    logic [8:0] stb; // svc, wdctl, prc, pclr, sclr, psel, wait, wake, monitor
    logic pseudo_stop, windowed, wd_pse, irq_en, p_pse, mon_en, sce, scie, psel_in;
    logic [2:0] wd_rate;
    logic [3:0] p_rate;
    logic [15:0] svc_data;
    wdc_wait_cfg_type wait_cfg;
    logic wd_rst, mf_rst, p_flag, p_irq, sc_flag, sc_irq, sc_mode, pll_sel, pll_en, regu_en, core_en, sys_en;
    logic osc_red, w_act;
    int fail_count = 0;
    int comparisons = 0;
    int t;
    wdc_tb_row_type rows[7] = '{
        '{6'h00, 5'h1e}, '{6'h20, 5'h0c}, '{6'h10, 5'h16}, '{6'h08, 5'h12},
        '{6'h01, 5'h1f}, '{6'h06, 5'h1e}, '{6'h3f, 5'h01}};

    wdc_top #(.CHECK_WINDOW(64), .OSC_EDGES(8)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
        .osc_clk_pin(osc_clk_pin), .monitor_fail_pin(stb[8]), .pseudo_stop(pseudo_stop),
        .wait_instruction(stb[6]), .wake_irq(stb[7]), .wdctl_wr(stb[1]), .wd_rate_in(wd_rate),
        .windowed_service_enable(windowed), .watchdog_pseudo_stop_enable(wd_pse), .svc_wr(stb[0]),
        .svc_data(svc_data), .prc_wr(stb[2]), .periodic_rate_control(p_rate), .periodic_irq_enable(irq_en),
        .periodic_pseudo_stop_enable(p_pse), .periodic_flag_clr(stb[3]), .clock_monitor_enable(mon_en),
        .self_clock_enable(sce), .self_clock_irq_enable(scie), .self_clock_flag_clr(stb[4]),
        .pll_select_wr(stb[5]), .pll_select_in(psel_in), .wait_cfg(wait_cfg), .watchdog_reset(wd_rst),
        .monitor_fail_reset(mf_rst), .periodic_irq_flag(p_flag), .periodic_irq(p_irq),
        .self_clock_irq_flag(sc_flag), .self_clock_irq(sc_irq), .self_clock_mode(sc_mode),
        .pll_clock_select(pll_sel), .pll_enable(pll_en), .regulator_enable(regu_en), .core_clk_en(core_en),
        .sys_clk_en(sys_en), .osc_reduced(osc_red), .wait_active(w_act));

    // clocks; oscillator runs at a quarter of ref_clk, toggled on ref_clk falling edges
    always #20 ref_clk = ~ref_clk;
    always #80 if (osc_run) osc_clk_pin = ~osc_clk_pin;

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one-cycle strobe; clearing the whole vector keeps each signal single-driven
    // the extra edge lets the strobe's effect land before the caller samples
    task automatic strobe(input int i);
        @(posedge ref_clk);
        stb <= 9'h001 << i;
        @(posedge ref_clk);
        stb <= '0;
        @(posedge ref_clk);
    endtask

    task automatic svc(input logic [15:0] d);
        svc_data <= d;
        strobe(0);
    endtask

    task automatic wdctl(input logic [2:0] r, input logic w, input logic p);
        wd_rate <= r;
        windowed <= w;
        wd_pse <= p;
        strobe(1);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return wd_rst;
            1: return mf_rst;
            2: return p_flag;
            3: return sc_mode;
            default: return !sc_mode;
        endcase
    endfunction

    // bounded wait; t ends at n when the event never came
    task automatic wait_for(input int s, input int n, output int tt);
        tt = 0;
        while (tt < n && pick(s) !== 1'b1)
        begin
            @(posedge ref_clk);
            tt++;
        end
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        rstn <= 1'b0;
        cyc(2);
        rstn <= 1'b1;
        cyc(100);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watchdog sized well above the ~60k cycles the sequence needs
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        fail_count++;
        wrap_up();
    end

    initial
    begin
        {rstn, stb, pseudo_stop, windowed, wd_pse, irq_en, p_pse, mon_en, sce, scie, psel_in} = '0;
        {wd_rate, p_rate, svc_data, wait_cfg} = '0;
        cyc(2);
        rstn <= 1'b1;
        cyc(100);
        chk("reset_state", 9'h01e, {wd_rst, mf_rst, p_flag, sc_mode, pll_en, regu_en, core_en, sys_en, w_act});
        // wait entry and exit per gating combination
        foreach (rows[i])
        begin
            psel_in <= 1'b1;
            strobe(5);
            wait_cfg <= rows[i].cfg;
            strobe(6);
            cyc(8);
            chk("wait_entry", rows[i].exp, {pll_en, core_en, sys_en, pll_sel, osc_red});
            chk("wait_active", 1'b1, w_act);
            strobe(7);
            cyc(4);
            chk("wait_exit", {3'b111, rows[i].exp[1], 2'b00}, {pll_en, core_en, sys_en, pll_sel, osc_red, w_act});
        end
        // external reset in deep wait restores defaults without a clock edge
        strobe(6);
        cyc(8);
        rstn <= 1'b0;
        #1;
        chk("reset_in_wait", 9'h01e, {wd_rst, mf_rst, p_flag, sc_mode, pll_en, regu_en, core_en, sys_en, w_act});
        wait_cfg <= '0;
        cyc(2);
        rstn <= 1'b1;
        cyc(100);
        // watchdog idle after reset and after a zero rate
        svc(16'h1234);
        wait_for(0, 10, t);
        chk("wd_off_after_reset", 16'd10, t[15:0]);
        wdctl(3'h1, 1'b0, 1'b0);
        wdctl(3'h0, 1'b0, 1'b0);
        svc(16'h1234);
        wait_for(0, 5000, t);
        chk("wd_stopped", 16'd5000, t[15:0]);
        wdctl(3'h1, 1'b0, 1'b0);
        svc(16'h1234);
        wait_for(0, 10, t);
        chk("wd_bad_value", 1'b1, t < 10);
        do_reset();
        // serviced watchdog survives, then expires one period after the last pair
        wdctl(3'h1, 1'b0, 1'b0);
        repeat (3)
        begin
            wait_for(0, 3000, t);
            chk("wd_serviced", 16'd3000, t[15:0]);
            svc(SVC_ARM);
            svc(SVC_FIRE);
        end
        wait_for(0, 4600, t);
        chk("wd_expiry", 1'b1, t > 3900 && t < 4300);
        do_reset();
        wdctl(3'h1, 1'b1, 1'b0);
        svc(SVC_ARM);
        wait_for(0, 10, t);
        chk("wd_early_service", 1'b1, t < 10);
        do_reset();
        wdctl(3'h1, 1'b1, 1'b0);
        wait_for(0, 3300, t);
        chk("wd_window_wait", 16'd3300, t[15:0]);
        svc(SVC_ARM);
        svc(SVC_FIRE);
        wait_for(0, 3000, t);
        chk("wd_late_service", 16'd3000, t[15:0]);
        do_reset();
        pseudo_stop <= 1'b1;
        wdctl(3'h1, 1'b0, 1'b0);
        wait_for(0, 4600, t);
        chk("wd_frozen", 16'd4600, t[15:0]);
        chk("regulator_pseudo", 1'b0, regu_en);
        wdctl(3'h1, 1'b0, 1'b1);
        wait_for(0, 4600, t);
        chk("wd_pseudo_stop", 1'b1, t < 4600);
        pseudo_stop <= 1'b0;
        do_reset();
        // periodic timer: rate, auto-reload, restart on write, stop on zero
        irq_en <= 1'b1;
        p_rate <= 4'h1;
        strobe(2);
        wait_for(2, 4600, t);
        chk("pt_first", 1'b1, t > 3900 && t < 4300);
        cyc(1);
        chk("pt_irq", 1'b1, p_irq);
        pseudo_stop <= 1'b1;
        p_pse <= 1'b1;
        strobe(3);
        wait_for(2, 4600, t);
        chk("pt_reload", 1'b1, t > 3900 && t < 4300);
        p_pse <= 1'b0;
        strobe(3);
        wait_for(2, 4600, t);
        chk("pt_frozen", 16'd4600, t[15:0]);
        pseudo_stop <= 1'b0;
        cyc(2000);
        strobe(2);
        wait_for(2, 4600, t);
        chk("pt_restart", 1'b1, t > 3900 && t < 4300);
        p_rate <= 4'h0;
        strobe(2);
        strobe(3);
        wait_for(2, 5000, t);
        chk("pt_stopped", 16'd5000, t[15:0]);
        // clock monitor: ignored, reset, then self-clock wake from wait
        strobe(8);
        wait_for(3, 10, t);
        chk("cm_disabled", 16'd10, t[15:0]);
        mon_en <= 1'b1;
        strobe(8);
        wait_for(1, 10, t);
        chk("cm_reset", 1'b1, t < 10);
        do_reset();
        {sce, scie, psel_in} <= 3'b111;
        strobe(5);
        strobe(6);
        cyc(8);
        osc_run = 1'b0;
        strobe(8);
        wait_for(3, 10, t);
        chk("scm_entry", 3'b110, {t < 10, sc_flag, pll_sel});
        cyc(4);
        chk("scm_wake", 4'b0111, {w_act, pll_en, regu_en, sc_irq});
        cyc(200);
        chk("scm_holds", 1'b1, sc_mode);
        osc_run = 1'b1;
        wait_for(4, 300, t);
        chk("scm_exit", 1'b1, t < 300);
        strobe(4);
        cyc(2);
        chk("scm_flag_clr", 2'b00, {sc_flag, sc_irq});
        wrap_up();
    end
endmodule // testbench
